// file: design/ctc_pkg.sv
// Shared constants, state encodings and carriers for the coax transceiver control
package ctc_pkg;
    // Clock rate of the control logic
    localparam int CLK_MHZ = 50;

    // Least time rounds up to whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time rounds down, never below one
    function automatic int cyc_max(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Times as specified, in their own units
    localparam int RX_ON_MAX_NS = 500;
    localparam int RX_HIGH_NS = 250;
    localparam int RX_BLANK_NS = 1000;
    localparam int TX_ON_NS = 15;
    localparam int TX_OFF_NS = 250;
    localparam int CD_ON_MAX_NS = 700;
    localparam int CD_IDLE_NS = 170;
    localparam int CD_FREQ_MHZ = 10;
    localparam int HB_DELAY_NS = 1000;
    localparam int HB_LEN_NS = 1000;
    localparam int UNJAB_NS = 450;
    localparam int JABBER_MS = 30;

    // Derived cycle counts
    localparam int RX_ON_MAX_CYC = cyc_max(RX_ON_MAX_NS);
    localparam int RX_HIGH_CYC = cyc_min(RX_HIGH_NS);
    localparam int RX_BLANK_CYC = cyc_min(RX_BLANK_NS);
    localparam int TX_ON_CYC = cyc_min(TX_ON_NS);
    localparam int TX_OFF_CYC = cyc_min(TX_OFF_NS);
    localparam int CD_ON_MAX_CYC = cyc_max(CD_ON_MAX_NS);
    localparam int CD_IDLE_CYC = cyc_min(CD_IDLE_NS);
    localparam int CD_PER_CYC = CLK_MHZ / CD_FREQ_MHZ;
    localparam int CD_LOW_CYC = CD_PER_CYC / 2;
    localparam int HB_DELAY_CYC = cyc_min(HB_DELAY_NS);
    localparam int HB_LEN_CYC = cyc_min(HB_LEN_NS);
    localparam int UNJAB_CYC = cyc_min(UNJAB_NS);
    localparam int JABBER_CYC = JABBER_MS * 1000 * CLK_MHZ;

    // Counter widths
    localparam int CNT_W = 6;
    localparam int PH_W = 3;
    localparam int GAP_W = 4;

    typedef enum logic [1:0] {
        CTC_RX_IDLE = 2'b00,
        CTC_RX_ON = 2'b01,
        CTC_RX_HOLD = 2'b10
    } ctc_rx_st_t;

    typedef enum logic [1:0] {
        CTC_TX_IDLE = 2'b00,
        CTC_TX_ON = 2'b01,
        CTC_TX_JAB = 2'b10,
        CTC_TX_UNJAB = 2'b11
    } ctc_tx_st_t;

    typedef enum logic [1:0] {
        CTC_HB_IDLE = 2'b00,
        CTC_HB_WAIT = 2'b01,
        CTC_HB_BURST = 2'b10
    } ctc_hb_st_t;

    // Cable side comparator results and recovered bit
    typedef struct packed {
        logic below_squelch;
        logic beyond_coll;
        logic level_high;
        logic bit_val;
        logic bit_valid;
    } ctc_cable_t;
endpackage

// file: design/ctc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ctc_fifo #(
    parameter int W = 1,
    parameter int D = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    // Pointers wrap by overflow, so depth must be a power of two
    if (D < 2 || (D & (D - 1)) != 0 || W < 1)
    begin : g_chk
        $error("ctc_fifo: depth must be a power of two >= 2");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic nfull;
        logic nempty;
        logic [W-1:0] head;
    } ctc_fifo_st_t;

    ctc_fifo_st_t s_reg;
    ctc_fifo_st_t s_next;
    logic push;
    logic pop;

    // Flags and head word are flops so the ports carry no decode logic
    always_comb
    begin
        push = in_valid_i & s_reg.nfull;
        pop = s_reg.nempty & out_ready_i;
        s_next = s_reg;
        if (push)
        begin
            s_next.mem[s_reg.wp] = in_data_i;
            s_next.wp = AW'(s_reg.wp + 1'b1);
        end
        if (pop)
        begin
            s_next.rp = AW'(s_reg.rp + 1'b1);
        end
        s_next.cnt = CW'(s_reg.cnt + CW'(push) - CW'(pop));
        s_next.nfull = (s_next.cnt != CW'(D));
        s_next.nempty = (s_next.cnt != '0);
        s_next.head = s_next.mem[s_next.rp];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.nfull <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign in_ready_o = s_reg.nfull;
    assign out_valid_o = s_reg.nempty;
    assign out_data_o = s_reg.head;
endmodule
`default_nettype wire

// file: design/ctc_core.sv
// Coax transceiver timing control: squelch, collision, heartbeat, jabber
`timescale 1ns/100ps
`default_nettype none
module ctc_core #(
    parameter int JABBER_CYC = ctc_pkg::JABBER_CYC,
    parameter int RX_FIFO_D = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ctc_pkg::ctc_cable_t cable_i,
    input wire logic tx_neg_i,
    input wire logic pulse_test_enable_i,
    input wire logic rx_ready_i,
    output logic cable_ready_o,
    output logic rx_data_o,
    output logic rx_valid_o,
    output logic tx_drive_o,
    output logic tx_inhibit_o,
    output logic collision_out_o,
    output logic collision_en_o
);
    import ctc_pkg::*;

    localparam int JW = $clog2(JABBER_CYC + 1);
    localparam int RXMAX = RX_ON_MAX_CYC;
    localparam int CDMAX = CD_ON_MAX_CYC;

    // Counter widths must hold the longest interval
    if (JABBER_CYC < 2 || RX_BLANK_CYC >= (1 << CNT_W) || CD_IDLE_CYC >= (1 << GAP_W))
    begin : g_chk
        $error("ctc_core: counter widths cannot serve the timing");
    end

    typedef struct packed {
        ctc_rx_st_t rx;
        logic [CNT_W-1:0] rxc;
        ctc_tx_st_t tx;
        logic [CNT_W-1:0] txc;
        logic [JW-1:0] jab;
        ctc_hb_st_t hb;
        logic [CNT_W-1:0] hbc;
        logic run;
        logic [PH_W-1:0] ph;
        logic [GAP_W-1:0] gap;
        logic cd;
        logic drv;
    } ctc_core_st_t;

    ctc_core_st_t s_reg;
    ctc_core_st_t s_next;
    logic coll_req;
    logic rx_wr;
    // Saturating-free increment used by the rxc, txc and hbc interval counters
    function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
        return CNT_W'(v + 1'b1);
    endfunction

    // Cable bits enter the buffer only while the receiver is on
    assign rx_wr = (s_reg.rx == CTC_RX_ON) & cable_i.bit_valid;

    ctc_fifo #(
        .W(1),
        .D(RX_FIFO_D)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(rx_wr),
        .in_data_i(cable_i.bit_val),
        .in_ready_o(cable_ready_o),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // Collision source: cable level, heartbeat, or jabber hold
    assign coll_req = cable_i.beyond_coll
        | (s_reg.hb == CTC_HB_BURST)
        | (s_reg.tx == CTC_TX_JAB)
        | (s_reg.tx == CTC_TX_UNJAB);

    // Next state of the whole block
    always_comb
    begin
        s_next = s_reg;
        // Receiver squelch; turn-off is timed so dribble bits are dropped
        case (s_reg.rx)
            CTC_RX_IDLE:
            begin
                s_next.rxc = '0;
                if (cable_i.below_squelch)
                begin
                    s_next.rx = CTC_RX_ON;
                end
            end
            CTC_RX_ON:
            begin
                if (!cable_i.level_high)
                begin
                    s_next.rxc = '0;
                end
                else if (s_reg.rxc == CNT_W'(RX_HIGH_CYC - 1))
                begin
                    s_next.rx = CTC_RX_HOLD;
                    s_next.rxc = '0;
                end
                else
                begin
                    s_next.rxc = inc(s_reg.rxc);
                end
            end
            CTC_RX_HOLD:
            begin
                if (s_reg.rxc == CNT_W'(RX_BLANK_CYC - 1))
                begin
                    s_next.rx = CTC_RX_IDLE;
                    s_next.rxc = '0;
                end
                else
                begin
                    s_next.rxc = inc(s_reg.rxc);
                end
            end
            default:
            begin
                s_next.rx = CTC_RX_IDLE;
                s_next.rxc = '0;
            end
        endcase
        // Transmit squelch and jabber; packet end is seen even when inhibited
        case (s_reg.tx)
            CTC_TX_IDLE:
            begin
                s_next.jab = '0;
                if (!tx_neg_i)
                begin
                    s_next.txc = '0;
                end
                else if (s_reg.txc == CNT_W'(TX_ON_CYC - 1))
                begin
                    s_next.tx = CTC_TX_ON;
                    s_next.txc = '0;
                end
                else
                begin
                    s_next.txc = inc(s_reg.txc);
                end
            end
            CTC_TX_ON, CTC_TX_JAB:
            begin
                if (s_reg.tx == CTC_TX_ON)
                begin
                    s_next.jab = JW'(s_reg.jab + 1'b1);
                end
                if (s_reg.tx == CTC_TX_ON && s_reg.jab == JW'(JABBER_CYC - 1))
                begin
                    s_next.tx = CTC_TX_JAB;
                end
                if (tx_neg_i)
                begin
                    s_next.txc = '0;
                end
                else if (s_reg.txc == CNT_W'(TX_OFF_CYC - 1))
                begin
                    s_next.txc = '0;
                    s_next.tx = (s_reg.tx == CTC_TX_ON) ? CTC_TX_IDLE : CTC_TX_UNJAB;
                end
                else
                begin
                    s_next.txc = inc(s_reg.txc);
                end
            end
            CTC_TX_UNJAB:
            begin
                if (s_reg.txc == CNT_W'(UNJAB_CYC - 1))
                begin
                    s_next.tx = CTC_TX_IDLE;
                    s_next.txc = '0;
                end
                else
                begin
                    s_next.txc = inc(s_reg.txc);
                end
            end
            default:
            begin
                s_next.tx = CTC_TX_IDLE;
                s_next.txc = '0;
            end
        endcase
        s_next.drv = (s_next.tx == CTC_TX_ON);
        // Heartbeat; a jabbed packet gets no heartbeat since collision is already shown
        case (s_reg.hb)
            CTC_HB_IDLE:
            begin
                s_next.hbc = '0;
                if (s_reg.tx == CTC_TX_ON && s_next.tx == CTC_TX_IDLE && pulse_test_enable_i)
                begin
                    s_next.hb = CTC_HB_WAIT;
                end
            end
            CTC_HB_WAIT:
            begin
                if (s_reg.hbc == CNT_W'(HB_DELAY_CYC - 1))
                begin
                    s_next.hb = CTC_HB_BURST;
                    s_next.hbc = '0;
                end
                else
                begin
                    s_next.hbc = inc(s_reg.hbc);
                end
            end
            CTC_HB_BURST:
            begin
                if (s_reg.hbc == CNT_W'(HB_LEN_CYC - 1))
                begin
                    s_next.hb = CTC_HB_IDLE;
                    s_next.hbc = '0;
                end
                else
                begin
                    s_next.hbc = inc(s_reg.hbc);
                end
            end
            default:
            begin
                s_next.hb = CTC_HB_IDLE;
                s_next.hbc = '0;
            end
        endcase
        // Collision oscillator; a burst always finishes its period, then idles high
        if (s_reg.run)
        begin
            s_next.ph = (s_reg.ph == PH_W'(CD_PER_CYC - 1)) ? '0 : PH_W'(s_reg.ph + 1'b1);
            if (!coll_req && s_reg.ph == PH_W'(CD_PER_CYC - 1))
            begin
                s_next.run = 1'b0;
                s_next.gap = '0;
            end
            s_next.cd = !s_next.run || (s_next.ph >= PH_W'(CD_LOW_CYC));
        end
        else
        begin
            s_next.cd = 1'b1;
            if (s_reg.gap != GAP_W'(CD_IDLE_CYC - 1))
            begin
                s_next.gap = GAP_W'(s_reg.gap + 1'b1);
            end
            else if (coll_req)
            begin
                s_next.run = 1'b1;
                s_next.ph = '0;
                s_next.cd = 1'b0;
            end
        end
    end

    // All counters and states start from known values
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.gap <= GAP_W'(CD_IDLE_CYC - 1);
            s_reg.cd <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    // Outputs taken straight from state flops
    assign tx_drive_o = s_reg.drv;
    assign tx_inhibit_o = s_reg.tx[1];
    assign collision_out_o = s_reg.cd;
    assign collision_en_o = s_reg.run;

    property p_rx_on;
        @(posedge clk_i) disable iff (rst_i)
        (s_reg.rx == CTC_RX_IDLE && cable_i.below_squelch) |-> ##[1:RXMAX] s_reg.rx == CTC_RX_ON;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver late to turn on");
    property p_rx_gate;
        @(posedge clk_i) disable iff (rst_i)
        $rose(s_reg.rx == CTC_RX_ON) |-> $past(cable_i.below_squelch);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("receiver on without squelch");
    property p_rx_blank;
        @(posedge clk_i) disable iff (rst_i)
        $fell(s_reg.rx == CTC_RX_HOLD) |-> $past(s_reg.rxc) == CNT_W'(RX_BLANK_CYC - 1);
    endproperty
    a_rx_blank: assert property (p_rx_blank) else $error("receiver blank time wrong");
    property p_rx_only;
        @(posedge clk_i) disable iff (rst_i)
        $rose(rx_valid_o) |-> $past(s_reg.rx == CTC_RX_ON) && $past(cable_i.bit_valid);
    endproperty
    a_rx_only: assert property (p_rx_only) else $error("write while receiver off");
    property p_tx_start;
        @(posedge clk_i) disable iff (rst_i)
        $rose(tx_drive_o) && !$past(tx_inhibit_o) |-> $past(tx_neg_i);
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("transmit start without input");
    property p_tx_stop;
        @(posedge clk_i) disable iff (rst_i)
        $fell(tx_drive_o) && !tx_inhibit_o |-> !$past(tx_neg_i) && !$past(tx_neg_i, 2);
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("transmit stopped early");
    property p_cd_on;
        @(posedge clk_i) disable iff (rst_i)
        cable_i.beyond_coll [*8] |-> ##[0:CDMAX] collision_en_o;
    endproperty
    a_cd_on: assert property (p_cd_on) else $error("collision not signalled");
    property p_cd_edges;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(collision_en_o) |-> !collision_out_o) and ($fell(collision_en_o) |-> collision_out_o);
    endproperty
    a_cd_edges: assert property (p_cd_edges) else $error("burst framing wrong");
    property p_cd_gap;
        @(posedge clk_i) disable iff (rst_i)
        $fell(collision_en_o) |-> !collision_en_o [*8] ##1 collision_out_o;
    endproperty
    a_cd_gap: assert property (p_cd_gap) else $error("idle gap too short");
    property p_hb;
        @(posedge clk_i) disable iff (rst_i)
        ($past(s_reg.tx) == CTC_TX_ON && s_reg.tx == CTC_TX_IDLE && $past(pulse_test_enable_i))
        |-> s_reg.hb == CTC_HB_WAIT;
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat not started");
    property p_hb_off;
        @(posedge clk_i) disable iff (rst_i)
        (!pulse_test_enable_i && s_reg.hb == CTC_HB_IDLE) |=> s_reg.hb == CTC_HB_IDLE;
    endproperty
    a_hb_off: assert property (p_hb_off) else $error("heartbeat not suppressed");
    property p_jab;
        @(posedge clk_i) disable iff (rst_i)
        $rose(tx_inhibit_o) |-> $past(s_reg.jab) == JW'(JABBER_CYC - 1);
    endproperty
    a_jab: assert property (p_jab) else $error("jabber fired at wrong time");
    property p_unjab;
        @(posedge clk_i) disable iff (rst_i)
        $fell(tx_inhibit_o) |-> $past(s_reg.txc) == CNT_W'(UNJAB_CYC - 1);
    endproperty
    a_unjab: assert property (p_unjab) else $error("unjab time wrong");

    c_rx: cover property (@(posedge clk_i) disable iff (rst_i) $fell(s_reg.rx == CTC_RX_HOLD));
    c_hb: cover property (@(posedge clk_i) disable iff (rst_i) $fell(s_reg.hb == CTC_HB_BURST));
    c_jab: cover property (@(posedge clk_i) disable iff (rst_i) $fell(tx_inhibit_o));
    c_cd: cover property (@(posedge clk_i) disable iff (rst_i) $rose(collision_en_o));
endmodule
`default_nettype wire

// file: testbench/ctc_cable_model.sv
// Cable-side model: squelch and collision levels plus recovered bit strobes
`timescale 1ns/100ps
`default_nettype none
module ctc_cable_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pkt_i,
    input wire logic coll_i,
    input wire logic [3:0] pat_i,
    output var ctc_pkg::ctc_cable_t cable_o
);
    import ctc_pkg::*;

    logic in_pkt_reg;
    logic [1:0] idx_reg;

    // Bits trail the squelch level by one cycle so the receiver is already on
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_pkt_reg <= 1'b0;
            idx_reg <= 2'h0;
            cable_o <= 5'h04;
        end
        else
        begin
            in_pkt_reg <= pkt_i;
            cable_o.below_squelch <= pkt_i;
            cable_o.level_high <= ~pkt_i;
            cable_o.beyond_coll <= coll_i;
            cable_o.bit_valid <= pkt_i & in_pkt_reg;
            if (pkt_i && in_pkt_reg)
            begin
                cable_o.bit_val <= pat_i[idx_reg];
                idx_reg <= idx_reg + 2'h1;
            end
            else
            begin
                // An idle line never keeps showing the last bit
                cable_o.bit_val <= ~cable_o.bit_val;
                idx_reg <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/coax_transceiver_timing_control_tb_top.sv
// Self-checking bench for the coax transceiver timing control
`timescale 1ns/100ps
`default_nettype none
module coax_transceiver_timing_control_tb_top;
    import ctc_pkg::*;

    // Short jabber limit keeps the run brief
    localparam int JAB = 200;

    typedef struct {
        int len;
        logic pulse_test_enable;
        int drv;
        logic hb;
    } ctc_row_t;

    logic clk_i;
    logic rst_i;
    logic tx_neg_i;
    logic pulse_test_enable_i;
    logic rx_ready_i;
    logic pkt;
    logic coll;
    logic [3:0] pat;
    ctc_cable_t cable;
    logic cable_ready_o;
    logic rx_data_o;
    logic rx_valid_o;
    logic tx_drive_o;
    logic tx_inhibit_o;
    logic collision_out_o;
    logic collision_en_o;
    int n_fail = 0;
    int check_count = 0;
    ctc_row_t rows[3] = '{'{1, 1'b1, TX_OFF_CYC, 1'b1}, '{5, 1'b0, 4 + TX_OFF_CYC, 1'b0},
        '{20, 1'b1, 19 + TX_OFF_CYC, 1'b1}};

    ctc_cable_model PARTNER (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pkt_i(pkt),
        .coll_i(coll),
        .pat_i(pat),
        .cable_o(cable)
    );

    ctc_core #(.JABBER_CYC(JAB), .RX_FIFO_D(4)) DUT (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cable_i(cable),
        .tx_neg_i(tx_neg_i),
        .pulse_test_enable_i(pulse_test_enable_i),
        .rx_ready_i(rx_ready_i),
        .cable_ready_o(cable_ready_o),
        .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o),
        .tx_drive_o(tx_drive_o),
        .tx_inhibit_o(tx_inhibit_o),
        .collision_out_o(collision_out_o),
        .collision_en_o(collision_en_o)
    );

    // Free-running 50 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    function automatic logic inr(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 1200 cycles
    initial
    begin
        #(20 * 8000);
        n_fail++;
        final_report();
    end

    // Main sequence, inputs change on the falling edge only
    initial
    begin
        int drv;
        int last;
        int hb_on;
        int hb_len;
        int c;
        int lows;
        tx_neg_i = 1'b0;
        pulse_test_enable_i = 1'b1;
        rx_ready_i = 1'b0;
        pkt = 1'b0;
        coll = 1'b0;
        pat = 4'hB;
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        check("reset outs", {tx_drive_o, tx_inhibit_o, collision_en_o, collision_out_o,
            rx_valid_o, cable_ready_o}, 6'h05);
        // Transmit rows: length of terminal activity against drive time and heartbeat
        foreach (rows[i])
        begin
            pulse_test_enable_i = rows[i].pulse_test_enable;
            tx_neg_i = 1'b1;
            drv = 0;
            last = 0;
            hb_on = 0;
            hb_len = 0;
            for (int k = 0; k < 250; k++)
            begin
                tick(1);
                if (k == rows[i].len - 1)
                    tx_neg_i = 1'b0;
                if (tx_drive_o === 1'b1)
                begin
                    drv++;
                    last = k;
                end
                if (collision_en_o === 1'b1 && hb_on == 0)
                    hb_on = k;
                if (collision_en_o === 1'b1)
                    hb_len++;
            end
            check("drive span", drv, rows[i].drv);
            check("heartbeat seen", hb_on > 0, rows[i].hb);
            check("heartbeat len", rows[i].pulse_test_enable ? inr(hb_len, HB_LEN_CYC - 1,
                HB_LEN_CYC + CD_PER_CYC + 1) : hb_len == 0, 1'b1);
            if (rows[i].pulse_test_enable)
                check("heartbeat delay", inr(hb_on - last, HB_DELAY_CYC - 2,
                    HB_DELAY_CYC + 4), 1'b1);
            check("no loopback", rx_valid_o, 1'b0);
        end
        // Fill the receive FIFO with the terminal stalled, then drain in order
        pulse_test_enable_i = 1'b1;
        pkt = 1'b1;
        tick(7);
        pkt = 1'b0;
        check("fifo full", {rx_valid_o, cable_ready_o}, 2'h2);
        for (int i = 0; i < 4; i++)
        begin
            check("rx bit", {rx_valid_o, rx_data_o}, {1'b1, pat[i]});
            rx_ready_i = 1'b1;
            tick(1);
            rx_ready_i = 1'b0;
            tick(1);
        end
        check("rx drained", rx_valid_o, 1'b0);
        // A packet inside the blanking time after the receiver shut off is ignored
        tick(10);
        pkt = 1'b1;
        tick(6);
        pkt = 1'b0;
        tick(20);
        check("blanked rx", rx_valid_o, 1'b0);
        tick(40);
        pkt = 1'b1;
        tick(3);
        pkt = 1'b0;
        tick(3);
        check("rx again", rx_valid_o, 1'b1);
        rx_ready_i = 1'b1;
        tick(4);
        rx_ready_i = 1'b0;
        // Cable level past threshold with no local transmit gives a burst
        coll = 1'b1;
        c = 0;
        while (collision_en_o !== 1'b1 && c < 100)
        begin
            tick(1);
            c++;
        end
        check("coll onset", inr(c, 1, CD_ON_MAX_CYC), 1'b1);
        check("coll first", collision_out_o, 1'b0);
        lows = 0;
        hb_len = 0;
        for (int k = 0; k < 40; k++)
        begin
            tick(1);
            lows += (collision_out_o === 1'b0);
            hb_len += (collision_en_o === 1'b1);
        end
        check("coll lows", lows, 8 * CD_LOW_CYC);
        check("coll steady", hb_len, 40);
        coll = 1'b0;
        c = 0;
        while (collision_en_o === 1'b1 && c < 50)
        begin
            tick(1);
            c++;
        end
        // Request again at once: the idle gap must still pass before a new burst
        coll = 1'b1;
        lows = 0;
        for (int k = 0; k < CD_IDLE_CYC; k++)
        begin
            lows += (collision_out_o !== 1'b1) || (collision_en_o !== 1'b0);
            tick(1);
        end
        check("coll idle", lows, 0);
        check("coll regap", collision_en_o, 1'b1);
        coll = 1'b0;
        // Endless transmit trips the jabber timer
        tx_neg_i = 1'b1;
        c = 0;
        while (tx_inhibit_o !== 1'b1 && c < 400)
        begin
            tick(1);
            c++;
        end
        check("jab time", inr(c, JAB - 2, JAB + 3), 1'b1);
        tick(5);
        check("jab outs", {tx_drive_o, collision_en_o}, 2'h1);
        tx_neg_i = 1'b0;
        c = 0;
        lows = 0;
        while (tx_inhibit_o === 1'b1 && c < 200)
        begin
            lows += (collision_en_o !== 1'b1);
            tick(1);
            c++;
        end
        check("unjab time", inr(c, TX_OFF_CYC + UNJAB_CYC - 2,
            TX_OFF_CYC + UNJAB_CYC + 3), 1'b1);
        check("unjab coll", lows, 0);
        // Second reset in the middle of a burst
        coll = 1'b1;
        tick(10);
        rst_i = 1'b1;
        tick(2);
        check("mid reset", {tx_drive_o, tx_inhibit_o, collision_en_o, collision_out_o,
            rx_valid_o, cable_ready_o}, 6'h05);
        rst_i = 1'b0;
        tick(2);
        check("reset gap", {collision_en_o, collision_out_o}, 2'h2);
        coll = 1'b0;
        final_report();
    end
endmodule
`default_nettype wire
